// File: hw/nested_irq_ctrl.sv
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
// Summary of operation
// RQ1: Tick timer is a 24-bit down counter, steps per tick clock, wraps at zero.
// RQ2: Any write to tick current value clears the counter to zero.
// RQ3: After zero, counter loads reload value next tick, then keeps decrementing.
// RQ4: Counter transition to zero sets the count-wrapped flag.
// RQ5: Reading tick control/status clears the count-wrapped flag.
// RQ6: Software should write current value before enabling; reset value undefined.
// RQ7: Zero reload keeps the counter at zero, disabling the timer.
// RQ8: Thirty-two interrupt lines, each with one of four priority levels.
// RQ9: Preempt running handler only when the new request is strictly higher.
// RQ10: Priority 0 is highest configurable level, 3 lowest.
// RQ11: All configurable priorities reset to level zero.
// RQ12: Reset, NMI and hard fault rank above all configurable levels.
// RQ13: Vectors: reset 1, NMI 2, fault 3, SVC 11, 14, tick 15, lines 16-47.
// RQ14: Lower lines 0-11 carry listed sources; line 7 reserved.
// RQ15: Upper lines 13,14,15,19,23,24,28,31 carry sources; others reserved.
// RQ16: Handler address is fetched from the vector table by hardware.
// RQ17: Eight core registers are pushed on entry, popped on exit.
// RQ18: Pending request at handler exit chains directly without unstack/restack.
// RQ19: Higher request during stacking or fetch is served first, no extra delay.
// RQ20: Handlers run in handler mode, normal code in thread mode.
// RQ21: Enables set and cleared by write-one registers; disabled lines still pend.
// RQ22: Pending set/clear by write-one registers; clearing leaves active alone.
// RQ23: Priorities in 8-bit fields, four per 32-bit register.
// RQ24: Vector table base fixed at zero; word n holds vector n address.
// RQ25: Tick reaching zero with interrupt enable set pends vector fifteen.
// RQ26: Equal priority ties go to the lowest vector number.
module nested_irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int STACK_CYCLES = 1 // Cycles per stacked word
) (
  input  wire logic              clk_sys,      // Core clock
  input  wire logic              resetn,       // Async reset, active low
  input  wire logic              hsel,         // AHB-Lite select
  input  wire logic [31:0]       haddr,        // AHB-Lite address
  input  wire logic [1:0]        htrans,       // AHB-Lite transfer type
  input  wire logic              hwrite,       // AHB-Lite write
  input  wire logic [2:0]        hsize,        // AHB-Lite size
  input  wire logic [31:0]       hwdata,       // AHB-Lite write data
  input  wire logic              hready,       // AHB-Lite ready in
  output logic [31:0]            hrdata,       // AHB-Lite read data
  output logic                   hreadyout,    // AHB-Lite ready out
  output logic                   hresp,        // AHB-Lite response
  input  wire logic [NUM_IRQ-1:0] irq_lines,   // Peripheral interrupt lines
  input  wire logic              nmi_pin,      // Non-maskable request pin
  input  wire logic              tick_ref_clk, // External tick reference
  input  wire logic              svc_req,      // Supervisor call pulse from core
  input  wire logic              fault_req,    // Hard fault pulse from core
  input  wire logic              exc_return,   // Handler return pulse from core
  output logic                   handler_mode, // High while in handler mode
  output logic [5:0]             active_vec,   // Running exception vector
  output logic                   vec_fetch,    // Vector table read strobe
  output logic [31:0]            vec_addr,     // Vector table read address
  output logic                   stack_push,   // Core state push strobe
  output logic                   stack_pop,    // Core state pop strobe
  output logic [3:0]             stack_idx,    // Stacked word index
  output logic                   handler_go    // Branch to fetched handler
);

  typedef enum logic [2:0] {S_THREAD, S_STACK, S_RUN, S_UNSTACK} seq_t;

  // Priority of one line as a rank, 0 highest
  function automatic logic [2:0] cfg_rank(input logic [1:0] p);
    cfg_rank = RANK_CFG0 + {1'b0, p}; // RQ10
  endfunction

  // Synchronisers for pins
  logic [NUM_IRQ-1:0] irq_s1_q, irq_s2_q;
  logic [1:0] nmi_s_q, ref_s_q;
  logic ref_d1_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_s1_q <= '0;
      irq_s2_q <= '0;
      nmi_s_q  <= 2'h0;
      ref_s_q  <= 2'h0;
      ref_d1_q <= 1'b0;
    end else begin
      irq_s1_q <= irq_lines;
      irq_s2_q <= irq_s1_q;
      nmi_s_q  <= {nmi_s_q[0], nmi_pin};
      ref_s_q  <= {ref_s_q[0], tick_ref_clk};
      ref_d1_q <= ref_s_q[1];
    end
  end

  // AHB-Lite address phase capture
  bus_req_t ph_q;
  logic wr_en, rd_en;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) ph_q <= '0;
    else if (hready) begin
      ph_q.req     <= hsel && htrans[1];
      ph_q.is_read <= !hwrite;
      ph_q.ofs     <= haddr[7:0];
    end
  end
  assign wr_en = ph_q.req && !ph_q.is_read;
  assign rd_en = hsel && htrans[1] && !hwrite && hready; // Read address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Tick timer state
  logic [TICK_W-1:0] tick_cnt_q, tick_rld_q;
  logic [2:0] tick_ctl_q;
  logic wrapped_q, tick_step, tick_zero_ev;
  assign tick_step = tick_ctl_q[TCTRL_EN_BIT] &&
                     (tick_ctl_q[TCTRL_SRC_BIT] ? 1'b1 : (ref_s_q[1] && !ref_d1_q));
  assign tick_zero_ev = tick_step && (tick_cnt_q == TICK_W'(1)); // RQ4

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= '0;
      tick_rld_q <= '0;
      tick_ctl_q <= 3'h0;
    end else begin
      if (wr_en && ph_q.ofs == OFS_TICK_CTRL) tick_ctl_q <= hwdata[2:0];
      if (wr_en && ph_q.ofs == OFS_TICK_RELOAD) tick_rld_q <= hwdata[TICK_W-1:0];
      if (wr_en && ph_q.ofs == OFS_TICK_CURRENT) tick_cnt_q <= '0; // RQ2
      else if (tick_step) begin
        if (tick_cnt_q == '0) tick_cnt_q <= tick_rld_q; // RQ3 RQ7
        else tick_cnt_q <= tick_cnt_q - TICK_W'(1); // RQ1
      end
    end
  end

  // Count-wrapped flag: cleared where hrdata samples it, so no wrap is lost; set wins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) wrapped_q <= 1'b0;
    else if (tick_zero_ev) wrapped_q <= 1'b1; // RQ4
    else if (rd_en && haddr[7:0] == OFS_TICK_CTRL) wrapped_q <= 1'b0; // RQ5
  end

  // Enables, pending and priorities
  logic [NUM_IRQ-1:0] en_q, pend_q, act_q;
  logic [1:0] prio_q [NUM_IRQ];
  logic [1:0] svc_prio_q, psv_prio_q, tick_prio_q;
  logic [4:0] sys_pend_q;
  logic nmi_d1_q, exit_chain_q;
  seq_t st_q;
  winner_t win, cur;
  logic take, preempt;
  logic [5:0] stk_vec_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) en_q <= '0;
    else if (wr_en && ph_q.ofs == OFS_SET_ENABLE) en_q <= en_q | hwdata; // RQ21
    else if (wr_en && ph_q.ofs == OFS_CLR_ENABLE) en_q <= en_q & ~hwdata; // RQ21
  end

  // Line pending: hardware set wins over software clear; taken line unpends
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) pend_q <= '0;
    else begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        if ((irq_s2_q[i] || (wr_en && ph_q.ofs == OFS_SET_PEND && hwdata[i])) && IRQ_LIVE_MASK[i])
          pend_q[i] <= 1'b1; // RQ14 RQ15 RQ21 RQ22
        else if ((wr_en && ph_q.ofs == OFS_CLR_PEND && hwdata[i]) ||
                 (take && win.vec == VEC_IRQ0 + 6'(i)))
          pend_q[i] <= 1'b0; // RQ22
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_IRQ; i++) prio_q[i] <= PRIO_RESET; // RQ11
      svc_prio_q  <= PRIO_RESET;
      psv_prio_q  <= PRIO_RESET;
      tick_prio_q <= PRIO_RESET;
      exit_chain_q <= 1'b0;
    end else if (wr_en) begin
      for (int i = 0; i < NUM_IRQ; i++)
        if (ph_q.ofs == OFS_PRIO_BASE + 8'((i / 4) * 4))
          prio_q[i] <= hwdata[(i % 4) * PRIO_FIELD_W + PRIO_LSB +: 2]; // RQ23
      if (ph_q.ofs == OFS_SYS_PRIO) begin
        svc_prio_q  <= hwdata[PRIO_LSB +: 2];
        psv_prio_q  <= hwdata[PRIO_FIELD_W + PRIO_LSB +: 2];
        tick_prio_q <= hwdata[2 * PRIO_FIELD_W + PRIO_LSB +: 2];
      end
      if (ph_q.ofs == OFS_CORE_CTRL) exit_chain_q <= hwdata[CCTRL_EXIT_BIT];
    end
  end

  // System exception pending bits
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sys_pend_q <= 5'h0;
      nmi_d1_q   <= 1'b0;
    end else begin
      nmi_d1_q <= nmi_s_q[1];
      for (int b = 0; b < 5; b++) begin
        if ((b == SPEND_NMI_BIT && nmi_s_q[1] && !nmi_d1_q) ||
            (b == SPEND_HF_BIT && fault_req) ||
            (b == SPEND_SVC_BIT && svc_req) ||
            (b == SPEND_TICK_BIT && tick_zero_ev && tick_ctl_q[TCTRL_IE_BIT]) || // RQ25
            (wr_en && ph_q.ofs == OFS_SYS_PEND && hwdata[b]))
          sys_pend_q[b] <= 1'b1;
        else if (take && win.vec == sys_vec(b)) sys_pend_q[b] <= 1'b0;
      end
    end
  end

  function automatic logic [5:0] sys_vec(input int b);
    case (b)
      SPEND_NMI_BIT: sys_vec = VEC_NMI;
      SPEND_HF_BIT:  sys_vec = VEC_HARD;
      SPEND_SVC_BIT: sys_vec = VEC_SVC;
      SPEND_PSV_BIT: sys_vec = VEC_PSV;
      default:       sys_vec = VEC_TICK;
    endcase
  endfunction

  // Arbitration: scan lowest vector first, strict compare keeps it on ties
  always_comb begin
    win = '{vec: VEC_NONE, rank: RANK_IDLE};
    if (sys_pend_q[SPEND_NMI_BIT]) win = '{vec: VEC_NMI, rank: RANK_NMI}; // RQ12
    if (sys_pend_q[SPEND_HF_BIT] && RANK_HARD < win.rank) win = '{vec: VEC_HARD, rank: RANK_HARD};
    if (sys_pend_q[SPEND_SVC_BIT] && cfg_rank(svc_prio_q) < win.rank)
      win = '{vec: VEC_SVC, rank: cfg_rank(svc_prio_q)}; // RQ13
    if (sys_pend_q[SPEND_PSV_BIT] && cfg_rank(psv_prio_q) < win.rank)
      win = '{vec: VEC_PSV, rank: cfg_rank(psv_prio_q)};
    if (sys_pend_q[SPEND_TICK_BIT] && cfg_rank(tick_prio_q) < win.rank)
      win = '{vec: VEC_TICK, rank: cfg_rank(tick_prio_q)};
    for (int i = 0; i < NUM_IRQ; i++)
      if (pend_q[i] && en_q[i] && cfg_rank(prio_q[i]) < win.rank) // RQ8 RQ21 RQ26
        win = '{vec: VEC_IRQ0 + 6'(i), rank: cfg_rank(prio_q[i])};
  end

  // Entry sequencer and nesting stack of preempted handlers
  logic [2:0] rank_stk_q [8];
  logic [5:0] vec_stk_q [8];
  logic [2:0] depth_q;
  logic [3:0] word_q;
  logic [7:0] wait_q;
  assign preempt = win.rank < cur.rank; // RQ9
  assign take = (st_q == S_STACK && word_q == STACK_WORDS - 4'h1 && wait_q == '0) ||
                (st_q == S_RUN && exc_return && preempt_after_exit()); // RQ18

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= S_THREAD;
      cur <= '{vec: VEC_NONE, rank: RANK_IDLE};
      stk_vec_q <= VEC_NONE;
      word_q <= 4'h0;
      wait_q <= '0;
      depth_q <= 3'h0;
      for (int k = 0; k < 8; k++) begin
        rank_stk_q[k] <= RANK_IDLE;
        vec_stk_q[k] <= VEC_NONE;
      end
    end else begin
      unique case (st_q)
        S_THREAD, S_RUN: begin
          if (exc_return && st_q == S_RUN) begin
            if (preempt_after_exit()) begin
              cur <= '{vec: win.vec, rank: win.rank}; // RQ18
              st_q <= S_RUN;
            end else begin
              st_q <= S_UNSTACK;
              word_q <= STACK_WORDS - 4'h1;
            end
          end else if (preempt) begin
            rank_stk_q[depth_q] <= cur.rank;
            vec_stk_q[depth_q] <= cur.vec;
            depth_q <= depth_q + 3'h1;
            st_q <= S_STACK; // RQ17
            word_q <= 4'h0;
            wait_q <= 8'(STACK_CYCLES - 1);
            stk_vec_q <= win.vec;
          end
        end
        S_STACK: begin
          stk_vec_q <= win.rank < rank_of(stk_vec_q) ? win.vec : stk_vec_q; // RQ19
          if (wait_q != '0) wait_q <= wait_q - 8'h1;
          else if (word_q == STACK_WORDS - 4'h1) begin
            cur <= '{vec: win.vec, rank: win.rank};
            st_q <= S_RUN;
          end else begin
            word_q <= word_q + 4'h1;
            wait_q <= 8'(STACK_CYCLES - 1);
          end
        end
        S_UNSTACK: begin
          if (word_q == '0) begin
            depth_q <= depth_q - 3'h1;
            cur <= '{vec: vec_stk_q[depth_q - 3'h1], rank: rank_stk_q[depth_q - 3'h1]};
            st_q <= (depth_q == 3'h1) ? S_THREAD : S_RUN;
          end else word_q <= word_q - 4'h1;
        end
        default: st_q <= S_THREAD;
      endcase
    end
  end

  // Tail chain when a pending request outranks the handler being resumed
  function automatic logic preempt_after_exit();
    preempt_after_exit = (depth_q != 3'h0) && win.vec != VEC_NONE &&
                         win.rank < rank_stk_q[depth_q - 3'h1];
  endfunction

  function automatic logic [2:0] rank_of(input logic [5:0] v);
    rank_of = (v == win.vec) ? win.rank : RANK_IDLE;
  endfunction

  // Core-facing strobes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vec_fetch <= 1'b0;
      vec_addr <= VTAB_BASE;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      stack_idx <= 4'h0;
      handler_go <= 1'b0;
    end else begin
      vec_fetch <= take || (st_q == S_RUN && exc_return && preempt_after_exit()); // RQ16
      vec_addr <= VTAB_BASE + {24'h0, win.vec, 2'b00}; // RQ24
      stack_push <= st_q == S_STACK && wait_q == '0; // RQ17
      stack_pop <= st_q == S_UNSTACK;
      stack_idx <= word_q;
      handler_go <= take;
    end
  end
  assign handler_mode = cur.vec != VEC_NONE; // RQ20
  assign active_vec = cur.vec;

  // Read data mux
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) hrdata <= '0;
    else if (rd_en) begin
      unique case (haddr[7:0])
        OFS_TICK_CTRL:    hrdata <= {15'h0, wrapped_q, 13'h0, tick_ctl_q};
        OFS_TICK_RELOAD:  hrdata <= {8'h0, tick_rld_q};
        OFS_TICK_CURRENT: hrdata <= {8'h0, tick_cnt_q};
        OFS_SET_ENABLE, OFS_CLR_ENABLE: hrdata <= en_q;
        OFS_SET_PEND, OFS_CLR_PEND:     hrdata <= pend_q;
        OFS_SYS_PEND:     hrdata <= {27'h0, sys_pend_q};
        OFS_CORE_STAT:    hrdata <= {20'h0, 5'(st_q), depth_q, handler_mode, 3'h0};
        default: begin
          hrdata <= '0;
          for (int r = 0; r < 8; r++)
            if (haddr[7:0] == OFS_PRIO_BASE + 8'(r * 4))
              for (int f = 0; f < 4; f++)
                hrdata[f * PRIO_FIELD_W + PRIO_LSB +: 2] <= prio_q[r * 4 + f];
          if (haddr[7:0] == OFS_SYS_PRIO)
            hrdata <= {8'h0, tick_prio_q, 6'h0, psv_prio_q, 6'h0, svc_prio_q, 6'h0};
        end
      endcase
    end
  end

  // Wrap flag set one cycle after the zero step
  wrap_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    tick_zero_ev |=> wrapped_q) else $error("wrap flag not set"); // RQ4
  // Current value write clears counter
  cur_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_en && ph_q.ofs == OFS_TICK_CURRENT |=> tick_cnt_q == '0)
    else $error("counter not cleared"); // RQ2
  // Zero reload holds zero
  zero_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    tick_cnt_q == '0 && tick_rld_q == '0 && !wr_en |=> tick_cnt_q == '0)
    else $error("counter left zero"); // RQ7
  // Preemption only on strict higher rank
  strict_pre_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q == S_RUN && !exc_return && win.rank >= cur.rank |=> st_q != S_STACK)
    else $error("preempted on equal rank"); // RQ9
  // Pushed word index stays below eight
  push_count_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    stack_push |-> stack_idx < STACK_WORDS) else $error("stack index high"); // RQ17
  // Vector fetch address is word aligned
  vec_addr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    vec_fetch |-> vec_addr[1:0] == 2'b00) else $error("vector addr misaligned"); // RQ24
  // Read clears flag when no wrap
  flag_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_en && haddr[7:0] == OFS_TICK_CTRL && !tick_zero_ev |=> !wrapped_q)
    else $error("flag not cleared on read"); // RQ5
  // Handler mode while an exception runs
  mode_run_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q == S_RUN |-> handler_mode) else $error("not in handler mode"); // RQ20

endmodule

// File: pkg/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_TICK_CTRL    = 8'h00;
  localparam logic [7:0] OFS_TICK_RELOAD  = 8'h04;
  localparam logic [7:0] OFS_TICK_CURRENT = 8'h08;
  localparam logic [7:0] OFS_SET_ENABLE   = 8'h10;
  localparam logic [7:0] OFS_CLR_ENABLE   = 8'h14;
  localparam logic [7:0] OFS_SET_PEND     = 8'h18;
  localparam logic [7:0] OFS_CLR_PEND     = 8'h1c;
  localparam logic [7:0] OFS_PRIO_BASE    = 8'h20;
  localparam logic [7:0] OFS_SYS_PEND     = 8'h40;
  localparam logic [7:0] OFS_SYS_PRIO     = 8'h44;
  localparam logic [7:0] OFS_CORE_CTRL    = 8'h48;
  localparam logic [7:0] OFS_CORE_STAT    = 8'h4c;

  // Tick control fields
  localparam int TCTRL_EN_BIT    = 0;
  localparam int TCTRL_IE_BIT    = 1;
  localparam int TCTRL_SRC_BIT   = 2;
  localparam int TCTRL_FLAG_BIT  = 16;

  // System pend fields and core control fields
  localparam int SPEND_NMI_BIT   = 0;
  localparam int SPEND_HF_BIT    = 1;
  localparam int SPEND_SVC_BIT   = 2;
  localparam int SPEND_PSV_BIT   = 3;
  localparam int SPEND_TICK_BIT  = 4;
  localparam int CCTRL_EXIT_BIT  = 0;

  // Widths and reset values
  localparam int TICK_W = 24;
  localparam int NUM_IRQ = 32;
  localparam int PRIO_FIELD_W = 8;
  localparam int PRIO_LSB = 6;
  localparam logic [1:0] PRIO_RESET = 2'h0;

  // Vector numbers
  localparam logic [5:0] VEC_NONE  = 6'h00;
  localparam logic [5:0] VEC_RESET = 6'h01;
  localparam logic [5:0] VEC_NMI   = 6'h02;
  localparam logic [5:0] VEC_HARD  = 6'h03;
  localparam logic [5:0] VEC_SVC   = 6'h0b;
  localparam logic [5:0] VEC_PSV   = 6'h0e;
  localparam logic [5:0] VEC_TICK  = 6'h0f;
  localparam logic [5:0] VEC_IRQ0  = 6'h10;

  // Effective ranks: 0 reset, 1 NMI, 2 hard fault, 3..6 levels 0..3, 7 idle
  localparam logic [2:0] RANK_NMI  = 3'h1;
  localparam logic [2:0] RANK_HARD = 3'h2;
  localparam logic [2:0] RANK_CFG0 = 3'h3;
  localparam logic [2:0] RANK_IDLE = 3'h7;

  // Vector table base and stacked word count
  localparam logic [31:0] VTAB_BASE = 32'h0000_0000;
  localparam logic [3:0] STACK_WORDS = 4'h8;

  // Lines that carry a source; others are reserved and masked
  localparam logic [31:0] IRQ_LIVE_MASK = 32'h9188_ef7f;

  typedef struct packed {
    logic [5:0]  vec;
    logic [2:0]  rank;
  } winner_t;

  typedef struct packed {
    logic        req;
    logic        is_read;
    logic [7:0]  ofs;
  } bus_req_t;

endpackage

// File: sim/core_model.sv
`timescale 1ns/10ps
// Core side: ends each open handler level with a return pulse after dly cycles
module core_model (
  input  wire logic       clk_sys,      // Core clock
  input  wire logic       resetn,       // Async reset, active low
  input  wire logic       handler_go,   // Handler branch strobe
  input  wire logic       handler_mode, // Handler mode level
  input  wire logic [7:0] dly,          // Handler run time in cycles
  output logic            exc_return    // Handler exit pulse
);
  logic [7:0] cnt_q;

  // Rearm while a handler level stays open, so nested levels also return
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q      <= 8'h00;
      exc_return <= 1'b0;
    end else begin
      exc_return <= handler_mode && cnt_q == 8'h01;
      if (handler_go || (handler_mode && cnt_q == 8'h00)) cnt_q <= dly;
      else if (!handler_mode) cnt_q <= 8'h00;
      else cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

// File: sim/nested_irq_ctrl_bench.sv
`timescale 1ns/10ps
module nested_irq_ctrl_bench;
  import irq_ctrl_pkg::*;
  localparam logic [5:0] SYS_V [4] = '{VEC_NMI, VEC_HARD, VEC_SVC, VEC_PSV};
  logic        clk_sys, resetn, hsel, hwrite, hreadyout, hresp, nmi_pin, tick_ref_clk;
  logic        svc_req, fault_req, exc_return, handler_mode, vec_fetch, handler_go;
  logic        stack_push, stack_pop;
  logic [31:0] haddr, hwdata, hrdata, vec_addr, irq_lines, rd, wd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  stack_idx;
  logic [5:0]  active_vec;
  logic [7:0]  dly;
  logic [5:0]  taken_q [$];
  int          error_cnt, n_compared, push_cnt, pop_cnt, i;

  nested_irq_ctrl #(.STACK_CYCLES(1)) uut (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq_lines(irq_lines), .nmi_pin(nmi_pin), .tick_ref_clk(tick_ref_clk),
    .svc_req(svc_req), .fault_req(fault_req), .exc_return(exc_return),
    .handler_mode(handler_mode), .active_vec(active_vec), .vec_fetch(vec_fetch),
    .vec_addr(vec_addr), .stack_push(stack_push), .stack_pop(stack_pop),
    .stack_idx(stack_idx), .handler_go(handler_go));
  core_model partner (.clk_sys(clk_sys), .resetn(resetn), .handler_go(handler_go),
    .handler_mode(handler_mode), .dly(dly), .exc_return(exc_return));

  // Clock and free-running tick reference
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) tick_ref_clk <= ~tick_ref_clk;

  // Record handler entries and stack traffic
  always @(posedge clk_sys) begin
    if (handler_go === 1'b1) taken_q.push_back(vec_addr[7:2]);
    if (stack_push === 1'b1) push_cnt++;
    if (stack_pop === 1'b1) pop_cnt++;
  end

  function automatic logic [31:0] prio_view(logic [31:0] w);
    return w & 32'hc0c0_c0c0;
  endfunction

  task check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (exp !== got) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Wait for the ready edge, bounded
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      end_of_test;
    end
  endtask

  // One single-word transfer: address phase, then data phase
  task xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] d);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, ofs};
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask

  task wr(input logic [7:0] ofs, input logic [31:0] d);
    xfer(1'b1, ofs, d);
  endtask

  task rdc(string what, input logic [7:0] ofs, input logic [31:0] exp);
    xfer(1'b0, ofs, 32'h0);
    check(what, exp, rd);
  endtask

  task expect_vec(input logic [5:0] v);
    int n;
    n = 0;
    while (taken_q.size() == 0 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (taken_q.size() == 0) begin
      error_cnt++;
      end_of_test;
    end
    check("taken vector", {26'h0, v}, {26'h0, taken_q.pop_front()});
  endtask

  task wait_idle;
    int n;
    n = 0;
    repeat (5) @(posedge clk_sys);
    while (handler_mode !== 1'b0 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    check("back in thread", 32'h0, {31'h0, handler_mode});
    repeat (10) @(posedge clk_sys);
  endtask

  initial begin
    {clk_sys, resetn, hsel, hwrite, nmi_pin, tick_ref_clk, svc_req, fault_req} = 8'h00;
    {haddr, hwdata, irq_lines, htrans, hsize, dly} = '0;
    hsize = 3'h2;
    dly = 8'd20;
    void'($urandom(32'h0b2d));
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rdc("tick ctrl", OFS_TICK_CTRL, 32'h0);
    rdc("unmapped", 8'hf0, 32'h0);
    for (i = 0; i < 8; i++) begin
      rdc("prio reset", OFS_PRIO_BASE + 8'(4 * i), 32'h0);
      wd = $urandom();
      wr(OFS_PRIO_BASE + 8'(4 * i), wd);
      rdc("prio field", OFS_PRIO_BASE + 8'(4 * i), prio_view(wd));
      wr(OFS_PRIO_BASE + 8'(4 * i), 32'h0);
    end
    wd = $urandom();
    wr(OFS_TICK_RELOAD, wd);
    rdc("reload", OFS_TICK_RELOAD, wd & 32'h00ff_ffff);
    $display("test registers done");
    wr(OFS_TICK_RELOAD, 32'd200);
    wr(OFS_TICK_CURRENT, 32'h0);
    wr(OFS_TICK_CTRL, 32'h5);
    rd = 32'h0;
    for (i = 0; i < 150 && rd[TCTRL_FLAG_BIT] !== 1'b1; i++) xfer(1'b0, OFS_TICK_CTRL, 32'h0);
    check("wrap flag", 32'h1, {31'h0, rd[TCTRL_FLAG_BIT]});
    rdc("flag after read", OFS_TICK_CTRL, 32'h5);
    xfer(1'b0, OFS_TICK_CURRENT, 32'h0);
    check("count in range", 32'h1, 32'(rd <= 32'd200 && rd > 32'd150));
    wr(OFS_TICK_CTRL, 32'h0);
    wr(OFS_TICK_CURRENT, $urandom());
    rdc("current cleared", OFS_TICK_CURRENT, 32'h0);
    wr(OFS_TICK_RELOAD, 32'h0);
    wr(OFS_TICK_CTRL, 32'h5);
    repeat (20) @(posedge clk_sys);
    rdc("zero reload", OFS_TICK_CURRENT, 32'h0);
    wr(OFS_TICK_RELOAD, 32'd50);
    wr(OFS_TICK_CTRL, 32'h1);
    repeat (40) @(posedge clk_sys);
    xfer(1'b0, OFS_TICK_CURRENT, 32'h0);
    check("ref clock count", 32'h1, 32'(rd > 32'd20 && rd < 32'd40));
    wr(OFS_TICK_CTRL, 32'h7);
    expect_vec(VEC_TICK);
    check("handler mode", 32'h1, {31'h0, handler_mode});
    check("active vector", {26'h0, VEC_TICK}, {26'h0, active_vec});
    wr(OFS_TICK_CTRL, 32'h0);
    wait_idle;
    taken_q.delete();
    $display("test tick done");
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      case (i)
        0: nmi_pin <= 1'b1;
        1: fault_req <= 1'b1;
        2: svc_req <= 1'b1;
        default: wr(OFS_SYS_PEND, 32'h8);
      endcase
      @(posedge clk_sys);
      {nmi_pin, fault_req, svc_req} <= 3'h0;
      expect_vec(SYS_V[i]);
      wait_idle;
    end
    $display("test system exceptions done");
    wr(OFS_SET_ENABLE, 32'h2100);
    rdc("set enable", OFS_SET_ENABLE, 32'h2100);
    rdc("clear enable", OFS_CLR_ENABLE, 32'h2100);
    wr(OFS_CLR_ENABLE, 32'h0100);
    rdc("enable after clear", OFS_SET_ENABLE, 32'h2000);
    wr(OFS_CLR_ENABLE, 32'hffff_ffff);
    irq_lines[13] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    irq_lines[13] <= 1'b0;
    rdc("disabled line pends", OFS_SET_PEND, 32'h2000);
    check("no entry", 32'h0, taken_q.size());
    wr(OFS_CLR_PEND, 32'hffff_ffff);
    rdc("pend cleared", OFS_CLR_PEND, 32'h0);
    wr(OFS_SET_PEND, ~IRQ_LIVE_MASK);
    rdc("reserved lines", OFS_SET_PEND, 32'h0);
    $display("test enable and pend done");
    wr(OFS_SET_ENABLE, 32'h6700);
    push_cnt = 0;
    pop_cnt = 0;
    wr(OFS_SET_PEND, 32'h0300);
    expect_vec(VEC_IRQ0 + 6'd8);
    expect_vec(VEC_IRQ0 + 6'd9);
    wait_idle;
    check("pushes", {28'h0, STACK_WORDS}, push_cnt);
    check("pops", {28'h0, STACK_WORDS}, pop_cnt);
    wr(OFS_PRIO_BASE + 8'h0c, 32'h0040_c000);
    wr(OFS_SET_PEND, 32'h6000);
    expect_vec(VEC_IRQ0 + 6'd14);
    expect_vec(VEC_IRQ0 + 6'd13);
    wait_idle;
    wr(OFS_PRIO_BASE + 8'h08, 32'h0000_4040);
    dly = 8'd120;
    push_cnt = 0;
    wr(OFS_SET_PEND, 32'h0100);
    expect_vec(VEC_IRQ0 + 6'd8);
    wr(OFS_SET_PEND, 32'h0200);
    expect_vec(VEC_IRQ0 + 6'd9);
    check("equal level waits", {28'h0, STACK_WORDS}, push_cnt);
    wait_idle;
    push_cnt = 0;
    wr(OFS_SET_PEND, 32'h0100);
    expect_vec(VEC_IRQ0 + 6'd8);
    wr(OFS_SET_PEND, 32'h0400);
    expect_vec(VEC_IRQ0 + 6'd10);
    check("higher preempts", {27'h0, STACK_WORDS, 1'b0}, push_cnt);
    wait_idle;
    $display("test priority done");
    end_of_test;
  end
endmodule
